// ### hdl/ucsfc_pkg.sv
// constants and types shared by the channel status and flow-control block
`default_nettype none
package ucsfc_pkg;
  // register offsets on the plain register port
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] ADR_DIV_LOW = 3'h0;
  localparam logic [2:0] ADR_DIV_HIGH = 3'h1;
  localparam logic [2:0] ADR_DIV_FRAC = 3'h2;
  localparam logic [2:0] ADR_ENH_FEAT = 3'h3;
  localparam logic [2:0] ADR_MODEM_CTL = 3'h4;
  localparam logic [2:0] ADR_LINE_STAT = 3'h5;
  localparam logic [2:0] ADR_MODEM_STAT = 3'h6;
  localparam logic [2:0] ADR_SCRATCH = 3'h7;
  // values after reset
  localparam logic [7:0] RST_DIV_LOW = 8'h01;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_SCRATCH = 8'hFF;
  // field positions
  localparam int unsigned MC_DTR = 0;
  localparam int unsigned MC_RTS = 1;
  localparam int unsigned MC_OP1 = 2;
  localparam int unsigned MC_OP2 = 3;
  localparam int unsigned MC_LOOP = 4;
  localparam int unsigned MC_XANY = 5;
  localparam int unsigned MC_IRDA = 6;
  localparam int unsigned MC_PRESC = 7;
  localparam int unsigned EF_ENH = 4;
  localparam int unsigned EF_ACTS = 7;
  localparam logic [7:0] MC_ENH_MASK = 8'hE0;
  localparam logic [7:0] DF_WR_MASK = 8'h3F;
  // pin index inside the synchronised group
  localparam int unsigned PIN_CTS = 0;
  localparam int unsigned PIN_DSR = 1;
  localparam int unsigned PIN_RI = 2;
  localparam int unsigned PIN_CD = 3;
  localparam int unsigned PIN_RX = 4;
  localparam int unsigned PIN_N = 5;
  // receive entry: data plus break, framing and parity tags
  localparam int unsigned RX_DATA_W = 8;
  localparam int unsigned RX_TAG_W = 3;
  localparam int unsigned RX_FIFO_DEPTH = 64;
  localparam int unsigned PRESC_LAST = 3;
  localparam int unsigned IR_PULSE_NUM = 3;
  localparam int unsigned IR_PULSE_DEN = 16;

  typedef enum logic [1:0] {
    SR_16X = 2'b00,
    SR_8X = 2'b01,
    SR_4X = 2'b10
  } ucsfc_rate_e;

  typedef enum logic [1:0] {
    TXF_NONE = 2'b00,
    TXF_PAIR1 = 2'b01,
    TXF_PAIR2 = 2'b10,
    TXF_BOTH = 2'b11
  } ucsfc_txfc_e;

  typedef enum logic [2:0] {
    RXF_NONE = 3'b000,
    RXF_PAIR1 = 3'b001,
    RXF_PAIR2 = 3'b010,
    RXF_EITHER = 3'b011,
    RXF_SEQ = 3'b100
  } ucsfc_rxfc_e;

  // sample ticks per bit for a sampling-rate field
  function automatic logic [4:0] ucsfc_ticks_per_bit(input logic [1:0] sel);
    logic [4:0] r;
    r = 5'h10;
    if (sel[1])
      r = 5'h04;
    else if (sel[0])
      r = 5'h08;
    return r;
  endfunction
endpackage
`default_nettype wire

// ### hdl/ucsfc_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous pins
`default_nettype none
module ucsfc_pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  input wire logic core_clk_i, // core clock
  input wire logic srst_i, // synchronous reset, high
  input wire logic [WIDTH-1:0] pin_i, // raw pins
  output logic [WIDTH-1:0] level_o // filtered levels
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl;
  } ucsfc_sync_s;

  ucsfc_sync_s st;
  ucsfc_sync_s next_st;

  generate
    if (WIDTH < 1)
    begin : g_bad
      $error("pin sync width must be at least one");
    end
  endgenerate

  // s1 feeds only s2; a change counts once s2 and s3 agree
  always_comb
  begin
    next_st = st;
    next_st.s1 = pin_i;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.lvl = (~(st.s2 ^ st.s3) & st.s3) | ((st.s2 ^ st.s3) & st.lvl);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st <= {IDLE, IDLE, IDLE, IDLE};
    else
      st <= next_st;
  end

  assign level_o = st.lvl;
endmodule
`default_nettype wire

// ### hdl/ucsfc_rx_fifo.sv
// receive fifo holding characters with error tags and a count of tagged entries
`default_nettype none
module ucsfc_rx_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned TAG_W = 3,
  parameter int unsigned DEPTH = 64
) (
  input wire logic core_clk_i, // core clock
  input wire logic srst_i, // synchronous reset, high
  input wire logic push_i, // write one entry, ignored when full
  input wire logic [WIDTH-1:0] push_data_i, // entry, tags in top bits
  input wire logic pop_i, // drop head entry, ignored when empty
  output logic [WIDTH-1:0] head_o, // head entry
  output logic full_o, // no room
  output logic empty_o, // nothing held
  output logic err_any_o // some entry carries a tag
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
    logic [CW-1:0] errs;
  } ucsfc_fifo_s;

  ucsfc_fifo_s st;
  ucsfc_fifo_s next_st;
  logic do_push;
  logic do_pop;
  logic push_tag;
  logic pop_tag;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || TAG_W >= WIDTH)
    begin : g_bad
      $error("fifo depth must be a power of two and tags narrower than entry");
    end
  endgenerate

  // pointers wrap naturally because depth is a power of two
  always_comb
  begin
    next_st = st;
    do_push = push_i && (st.cnt != CW'(DEPTH));
    do_pop = pop_i && (st.cnt != '0);
    push_tag = |push_data_i[WIDTH-1 -: TAG_W];
    pop_tag = |st.mem[st.rp][WIDTH-1 -: TAG_W];
    if (do_push)
    begin
      next_st.mem[st.wp] = push_data_i;
      next_st.wp = st.wp + AW'(1);
    end
    if (do_pop)
      next_st.rp = st.rp + AW'(1);
    next_st.cnt = st.cnt + CW'(do_push) - CW'(do_pop);
    next_st.errs = st.errs + CW'(do_push && push_tag) - CW'(do_pop && pop_tag);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign head_o = st.mem[st.rp];
  assign full_o = (st.cnt == CW'(DEPTH));
  assign empty_o = (st.cnt == '0);
  assign err_any_o = (st.errs != '0);
endmodule
`default_nettype wire

// ### hdl/ucsfc_channel.sv
// serial channel status, modem, divisor, infrared and flow-control selection
//
// The address map and the strobed register port are this design's own decisions.
`default_nettype none
module ucsfc_channel
  import ucsfc_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = ucsfc_pkg::RX_FIFO_DEPTH
) (
  input wire logic core_clk_i, // 125 MHz core clock
  input wire logic srst_i, // synchronous reset, high
  input wire logic [ucsfc_pkg::ADDR_W-1:0] addr_i, // register address
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after strobe
  input wire logic ier_rls_i, // line status interrupt enable
  input wire logic ier_ms_i, // modem status interrupt enable
  output logic rls_irq_o, // line status interrupt request
  output logic ms_irq_o, // modem status interrupt request
  input wire logic rx_done_i, // receiver finished a character
  input wire logic [7:0] rx_data_i, // received character
  input wire logic rx_perr_i, // its parity mismatched
  input wire logic rx_ferr_i, // its stop bit was bad
  input wire logic rx_brk_i, // line was low a whole frame
  input wire logic rx_pop_i, // host read receive holding
  output logic [7:0] rx_head_o, // receive holding contents
  input wire logic tx_fifo_empty_i, // transmit holding or fifo empty
  input wire logic tsr_empty_i, // transmit shift register empty
  input wire logic tx_data_i, // serial bit from transmitter
  output logic tx_stop_o, // hold off next character
  output logic sample_tick_o, // one pulse per sample period
  output logic [1:0] sample_rate_o, // sampling rate select
  output logic xon_any_o, // any character resumes transmit
  output logic [1:0] tx_fc_mode_o, // transmit flow-control pairs
  output logic [2:0] rx_fc_mode_o, // receive comparison mode
  output logic rx_core_o, // serial bit to receiver
  input wire logic rx_pin_i, // serial or infrared input pin
  output logic tx_pin_o, // serial or infrared output pin
  input wire logic cts_n_i, // clear to send, low active
  input wire logic dsr_n_i, // data set ready, low active
  input wire logic ring_indicator_n_i, // ring, low active
  input wire logic carrier_detect_n_i, // carrier, low active
  output logic rts_n_o, // request to send, low active
  output logic dtr_n_o // data terminal ready, low active
);
  typedef struct packed {
    logic [7:0] modem_control;
    logic [7:0] enhanced_feature;
    logic [7:0] divisor_fraction_and_sampling;
    logic [7:0] divisor_low;
    logic [7:0] divisor_high;
    logic [7:0] scratch_pad;
    logic [7:0] rdata;
    logic overrun;
    logic [3:0] delta;
    logic [3:0] lvl_prev;
    logic brk_hold;
    logic [1:0] presc;
    logic [16:0] bcnt;
    logic [3:0] facc;
    logic tick;
    logic [4:0] phase;
    logic tx_prev;
    logic [4:0] ir_hold;
    logic tx_pin;
    logic rx_core;
    logic tx_stop;
  } ucsfc_state_s;

  ucsfc_state_s st;
  ucsfc_state_s next_st;
  logic [PIN_N-1:0] pins;
  logic [RX_TAG_W+RX_DATA_W-1:0] head;
  logic [RX_TAG_W-1:0] head_tag;
  logic fifo_full;
  logic fifo_empty;
  logic fifo_err;
  logic push;
  logic loop;
  logic [3:0] lvl;
  logic [3:0] delta_set;
  logic [7:0] line_status;
  logic [7:0] modem_status;
  logic enh;
  logic [15:0] divisor;
  logic [4:0] per_bit;
  logic [4:0] pulse_len;
  logic presc_en;
  logic [4:0] carry_sum;

  ucsfc_pin_sync #(
    .WIDTH(PIN_N),
    .IDLE({PIN_N{1'b1}})
  ) u_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pin_i({rx_pin_i, carrier_detect_n_i, ring_indicator_n_i, dsr_n_i, cts_n_i}),
    .level_o(pins)
  );

  ucsfc_rx_fifo #(
    .WIDTH(RX_TAG_W + RX_DATA_W),
    .TAG_W(RX_TAG_W),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .push_i(push),
    .push_data_i({rx_brk_i, rx_ferr_i, rx_perr_i, rx_data_i}),
    .pop_i(rx_pop_i),
    .head_o(head),
    .full_o(fifo_full),
    .empty_o(fifo_empty),
    .err_any_o(fifo_err)
  );

  // decoded views of the registers
  assign loop = st.modem_control[MC_LOOP];
  assign enh = st.enhanced_feature[EF_ENH];
  assign divisor = {st.divisor_high, st.divisor_low};
  assign per_bit = ucsfc_ticks_per_bit(st.divisor_fraction_and_sampling[5:4]);
  assign pulse_len = (per_bit == 5'(IR_PULSE_DEN)) ? 5'(IR_PULSE_NUM) : 5'h01; // one tick below 16x
  assign head_tag = head[RX_TAG_W+RX_DATA_W-1 -: RX_TAG_W];
  // a second break while the line is still low is dropped, not queued
  assign push = rx_done_i && !fifo_full && !(rx_brk_i && st.brk_hold);

  // modem levels, low active; loopback takes them from the control bits
  always_comb
  begin
    if (loop)
      lvl = ~{st.modem_control[3:2], st.modem_control[0], st.modem_control[1]};
    else
      lvl = {pins[PIN_CD], pins[PIN_RI], pins[PIN_DSR], pins[PIN_CTS]};
    delta_set = st.lvl_prev ^ lvl;
    delta_set[PIN_RI] = lvl[PIN_RI] && !st.lvl_prev[PIN_RI];
  end

  // status as software sees it
  always_comb
  begin
    line_status = RST_ZERO;
    line_status[0] = !fifo_empty;
    line_status[1] = st.overrun;
    line_status[2] = !fifo_empty && head_tag[0];
    line_status[3] = !fifo_empty && head_tag[1];
    line_status[4] = (!fifo_empty && head_tag[2]) || st.brk_hold;
    line_status[5] = tx_fifo_empty_i;
    line_status[6] = tx_fifo_empty_i && tsr_empty_i;
    line_status[7] = fifo_err;
    modem_status = {~lvl, st.delta};
  end

  // prescaler enable: every cycle, or one in four
  assign presc_en = !st.modem_control[MC_PRESC] || (st.presc == 2'(PRESC_LAST));
  assign carry_sum = {1'b0, st.facc} + {1'b0, st.divisor_fraction_and_sampling[3:0]};

  always_comb
  begin
    next_st = st;
    // register writes; enhanced bits and fraction only while unlocked
    if (wr_i)
    begin
      case (addr_i)
        ADR_DIV_LOW: next_st.divisor_low = wdata_i;
        ADR_DIV_HIGH: next_st.divisor_high = wdata_i;
        ADR_DIV_FRAC:
        begin
          if (enh)
            next_st.divisor_fraction_and_sampling = wdata_i & DF_WR_MASK;
        end
        ADR_ENH_FEAT: next_st.enhanced_feature = wdata_i;
        ADR_MODEM_CTL:
        begin
          if (enh)
            next_st.modem_control = wdata_i;
          else
            next_st.modem_control = (st.modem_control & MC_ENH_MASK) |
                                    (wdata_i & ~MC_ENH_MASK);
        end
        ADR_SCRATCH: next_st.scratch_pad = wdata_i;
        default: next_st.scratch_pad = st.scratch_pad;
      endcase
    end
    // read data stands in the cycle after the strobe only
    next_st.rdata = RST_ZERO;
    if (rd_i)
    begin
      case (addr_i)
        ADR_DIV_LOW: next_st.rdata = st.divisor_low;
        ADR_DIV_HIGH: next_st.rdata = st.divisor_high;
        ADR_DIV_FRAC: next_st.rdata = st.divisor_fraction_and_sampling;
        ADR_ENH_FEAT: next_st.rdata = st.enhanced_feature;
        ADR_MODEM_CTL: next_st.rdata = st.modem_control;
        ADR_LINE_STAT: next_st.rdata = line_status;
        ADR_MODEM_STAT: next_st.rdata = modem_status;
        ADR_SCRATCH: next_st.rdata = st.scratch_pad;
        default: next_st.rdata = RST_ZERO;
      endcase
    end
    // overrun: a new event wins over the read that clears it
    next_st.overrun = (rx_done_i && fifo_full) ||
                      (st.overrun && !(rd_i && addr_i == ADR_LINE_STAT));
    // deltas: set wins over the clearing read
    next_st.lvl_prev = lvl;
    next_st.delta = delta_set |
                    (st.delta & {4{!(rd_i && addr_i == ADR_MODEM_STAT)}});
    // break holds until the filtered line goes high again
    if (rx_done_i && rx_brk_i)
      next_st.brk_hold = 1'b1;
    else if (pins[PIN_RX])
      next_st.brk_hold = 1'b0;
    // baud generator: count divisor, add one cycle on fraction carry
    next_st.tick = 1'b0;
    next_st.presc = st.presc + 2'h1;
    if (presc_en && divisor != 16'h0000)
    begin
      if (st.bcnt <= 17'h00001)
      begin
        next_st.tick = 1'b1;
        next_st.facc = carry_sum[3:0];
        next_st.bcnt = {1'b0, divisor} + 17'(carry_sum[4]);
      end
      else
        next_st.bcnt = st.bcnt - 17'h00001;
    end
    // bit phase, realigned to each transmitter bit edge
    next_st.tx_prev = tx_data_i;
    if (tx_data_i != st.tx_prev)
      next_st.phase = 5'h00;
    else if (st.tick)
      next_st.phase = (st.phase + 5'h01 >= per_bit) ? 5'h00 : st.phase + 5'h01;
    // infrared decode: a light pulse means a zero for one bit time
    if (st.modem_control[MC_IRDA] && pins[PIN_RX])
      next_st.ir_hold = per_bit;
    else if (st.tick && st.ir_hold != 5'h00)
      next_st.ir_hold = st.ir_hold - 5'h01;
    // pin routing; loopback idles the pin and turns tx into rx
    if (loop)
    begin
      next_st.tx_pin = !st.modem_control[MC_IRDA];
      next_st.rx_core = tx_data_i;
    end
    else if (st.modem_control[MC_IRDA])
    begin
      next_st.tx_pin = !tx_data_i && (st.phase < pulse_len);
      next_st.rx_core = (st.ir_hold == 5'h00);
    end
    else
    begin
      next_st.tx_pin = tx_data_i;
      next_st.rx_core = pins[PIN_RX];
    end
    // auto cts: transmitter finishes its character, then waits
    next_st.tx_stop = st.enhanced_feature[EF_ACTS] && lvl[PIN_CTS];
  end

  always_ff @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      st <= '0;
      st.divisor_low <= RST_DIV_LOW;
      st.scratch_pad <= RST_SCRATCH;
      st.lvl_prev <= 4'hF;
      st.tx_pin <= 1'b1;
      st.rx_core <= 1'b1;
      st.tx_prev <= 1'b1;
    end
    else
      st <= next_st;
  end

  // flow-control selection decode
  always_comb
  begin
    case (st.enhanced_feature[3:2])
      2'b10: tx_fc_mode_o = TXF_PAIR1;
      2'b01: tx_fc_mode_o = TXF_PAIR2;
      2'b11: tx_fc_mode_o = TXF_BOTH;
      default: tx_fc_mode_o = TXF_NONE;
    endcase
    case (st.enhanced_feature[1:0])
      2'b10: rx_fc_mode_o = RXF_PAIR1;
      2'b01: rx_fc_mode_o = RXF_PAIR2;
      2'b11:
      begin
        if (st.enhanced_feature[3] ^ st.enhanced_feature[2])
          rx_fc_mode_o = RXF_EITHER;
        else
          rx_fc_mode_o = RXF_SEQ;
      end
      default: rx_fc_mode_o = RXF_NONE;
    endcase
  end

  assign rdata_o = st.rdata;
  assign rx_head_o = head[RX_DATA_W-1:0];
  assign rls_irq_o = ier_rls_i && (st.overrun || line_status[4] ||
                     line_status[3] || line_status[2]);
  assign ms_irq_o = ier_ms_i && (st.delta != 4'h0);
  assign tx_stop_o = st.tx_stop;
  assign sample_tick_o = st.tick;
  assign sample_rate_o = st.divisor_fraction_and_sampling[5:4];
  assign xon_any_o = st.modem_control[MC_XANY];
  assign tx_pin_o = st.tx_pin;
  assign rx_core_o = st.rx_core;
  // modem outputs go inactive in loopback
  assign rts_n_o = loop || !st.modem_control[MC_RTS];
  assign dtr_n_o = loop || !st.modem_control[MC_DTR];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  a_ovr_no_push: assert property (rx_done_i && fifo_full |-> !push ##1 st.overrun)
    else $error("overrun did not flag or pushed into full fifo");
  a_dr_read: assert property (rd_i && addr_i == ADR_LINE_STAT |=> rdata_o[0] == $past(!fifo_empty))
    else $error("data ready read wrong");
  a_temt_read: assert property (rd_i && addr_i == ADR_LINE_STAT
      |=> rdata_o[6] == $past(tx_fifo_empty_i && tsr_empty_i))
    else $error("transmitter empty read wrong");
  a_msr_clear: assert property (rd_i && addr_i == ADR_MODEM_STAT && delta_set == 4'h0
      |=> st.delta == 4'h0)
    else $error("modem deltas not cleared by read");
  a_ri_rise: assert property ($rose(st.delta[PIN_RI]) |-> $past(lvl[PIN_RI], 1) &&
      !$past(st.lvl_prev[PIN_RI], 1))
    else $error("ring delta without rising ring");
  a_frac_lock: assert property (!enh |=> $stable(st.divisor_fraction_and_sampling))
    else $error("fraction changed while locked");
  a_ir_idle: assert property (st.modem_control[MC_IRDA] && !loop && tx_data_i
      |=> !tx_pin_o)
    else $error("infrared output not low while idle");
  a_cts_stop: assert property (st.enhanced_feature[EF_ACTS] && lvl[PIN_CTS]
      |=> tx_stop_o ##1 (tx_stop_o || !lvl[PIN_CTS] || !st.enhanced_feature[EF_ACTS]))
    else $error("auto cts did not stop transmitter");
  a_brk_once: assert property (rx_done_i && rx_brk_i && st.brk_hold |-> !push)
    else $error("second break character queued");
  a_loop_mirror: assert property (loop |-> modem_status[7:4] ==
      {st.modem_control[3:2], st.modem_control[0], st.modem_control[1]})
    else $error("loopback status does not mirror control");
endmodule
`default_nettype wire

// ### dv/ucsfc_modem_model.sv
// far-side modem and serial line model that drives the channel's input pins
`default_nettype none
module ucsfc_modem_model (
  input wire logic core_clk_i, // core clock, only times pin changes
  output logic cts_n_o, // clear to send, low active
  output logic dsr_n_o, // data set ready, low active
  output logic ring_indicator_n_o, // ring, low active
  output logic carrier_detect_n_o, // carrier, low active
  output logic line_o // serial line, idles at mark
);
  timeunit 1ns;
  timeprecision 1ps;
  // an idle modem leaves every control inactive and the line at mark
  initial {line_o, carrier_detect_n_o, ring_indicator_n_o, dsr_n_o, cts_n_o} = 5'h1F;
  // changes land just after an edge, so the synchroniser sees one clean step
  task automatic drive(input logic [4:0] v);
    @(posedge core_clk_i);
    {line_o, carrier_detect_n_o, ring_indicator_n_o, dsr_n_o, cts_n_o} <= v;
  endtask
endmodule
`default_nettype wire

// ### dv/ucsfc_channel_tb.sv
// self-checking bench for the channel status and flow-control block
`default_nettype none
module ucsfc_channel_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ucsfc_pkg::*;
  localparam logic [7:0] RST_TAB [8] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00, 8'hFF};
  localparam logic [3:0] FC_CODE [10] = '{4'h0, 4'h8, 4'h4, 4'hC, 4'h2, 4'h1, 4'hB, 4'h7, 4'hF, 4'h3};
  localparam logic [7:0] FC_EXP [10] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h01, 8'h02, 8'h0B, 8'h13,
    8'h1C, 8'h04};
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rx_data = 8'h00;
  logic wr = 1'b0, rd = 1'b0, ier_rls = 1'b1, ier_ms = 1'b1, rx_done = 1'b0;
  logic perr = 1'b0, ferr = 1'b0, brk = 1'b0, pop = 1'b0, txe = 1'b1, tsre = 1'b1;
  logic tx_bit = 1'b1;
  logic [7:0] rdata, head;
  logic rls_irq, ms_irq, tx_stop, tick, xon_any, rx_core, tx_pin, rts_n, dtr_n;
  logic [1:0] srate, txfc;
  logic [2:0] rxfc;
  logic cts_n, dsr_n, ri_n, cd_n, line;
  int fail_count = 0;
  int total_checks = 0;
  // 125 MHz core clock
  always #4 clk = ~clk;
  ucsfc_channel #(.FIFO_DEPTH(4)) dut_u (
    .core_clk_i(clk), .srst_i(srst), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .ier_rls_i(ier_rls), .ier_ms_i(ier_ms), .rls_irq_o(rls_irq),
    .ms_irq_o(ms_irq), .rx_done_i(rx_done), .rx_data_i(rx_data), .rx_perr_i(perr),
    .rx_ferr_i(ferr), .rx_brk_i(brk), .rx_pop_i(pop), .rx_head_o(head),
    .tx_fifo_empty_i(txe), .tsr_empty_i(tsre), .tx_data_i(tx_bit), .tx_stop_o(tx_stop),
    .sample_tick_o(tick), .sample_rate_o(srate), .xon_any_o(xon_any), .tx_fc_mode_o(txfc),
    .rx_fc_mode_o(rxfc), .rx_core_o(rx_core), .rx_pin_i(line), .tx_pin_o(tx_pin),
    .cts_n_i(cts_n), .dsr_n_i(dsr_n), .ring_indicator_n_i(ri_n),
    .carrier_detect_n_i(cd_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n));
  ucsfc_modem_model modem_u (.core_clk_i(clk), .cts_n_o(cts_n), .dsr_n_o(dsr_n),
    .ring_indicator_n_o(ri_n), .carrier_detect_n_o(cd_n), .line_o(line));
  task automatic complete_run();
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample it there
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(exp, rdata & m);
  endtask
  // tags are {break, framing, parity}
  task automatic push(input logic [7:0] d, input logic [2:0] tags);
    @(posedge clk);
    rx_data <= d;
    {brk, ferr, perr} <= tags;
    rx_done <= 1'b1;
    @(posedge clk);
    rx_done <= 1'b0;
  endtask
  task automatic pop_one();
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    #1;
  endtask
  // settle first: the generator may still be inside a period of the old divisor
  task automatic count_ticks(input int n, input logic [7:0] exp);
    logic [7:0] c;
    c = 8'h00;
    idle(8);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      c += {7'h00, tick};
    end
    chk(exp, c);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 8; i++)
      rd_chk(3'(i), RST_TAB[i]);
  endtask
  // hold reset four cycles, let the pin filters settle, then check every register
  task automatic apply_reset();
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    idle(8);
    t_reset();
  endtask
  // all four combinations of holding and shift empty; ends with both empty
  task automatic t_tx();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      {txe, tsre} <= 2'(k);
      rd_chk(ADR_LINE_STAT, {1'b0, k == 3, k > 1, 5'h00});
    end
  endtask
  task automatic t_rx();
    push(8'hA5, 3'b001);
    push(8'h3C, 3'b010);
    rd_chk(ADR_LINE_STAT, 8'hE5);
    chk(8'hA5, head);
    chk(8'h01, {7'h00, rls_irq});
    ier_rls <= !ier_rls;
    idle(1);
    chk(8'h00, {7'h00, rls_irq});
    ier_rls <= !ier_rls;
    pop_one();
    rd_chk(ADR_LINE_STAT, 8'hE9);
    pop_one();
    rd_chk(ADR_LINE_STAT, 8'h60);
    for (int i = 0; i < 5; i++)
      push(8'h10 + 8'(i), 3'b000);
    #1;
    chk(8'h01, {7'h00, rls_irq});
    rd_chk(ADR_LINE_STAT, 8'h63);
    rd_chk(ADR_LINE_STAT, 8'h61);
    for (int i = 0; i < 4; i++)
    begin
      chk(8'h10 + 8'(i), head);
      pop_one();
    end
    modem_u.drive(5'h0F);
    idle(8);
    chk(8'h00, {7'h00, rx_core});
    push(8'h00, 3'b100);
    rd_chk(ADR_LINE_STAT, 8'hF1);
    push(8'h00, 3'b100);
    pop_one();
    rd_chk(ADR_LINE_STAT, 8'h70);
    modem_u.drive(5'h1F);
    idle(8);
    rd_chk(ADR_LINE_STAT, 8'h60);
  endtask
  task automatic t_modem();
    modem_u.drive(5'h1E);
    idle(8);
    chk(8'h01, {7'h00, ms_irq});
    ier_ms <= !ier_ms;
    idle(1);
    chk(8'h00, {7'h00, ms_irq});
    ier_ms <= !ier_ms;
    rd_chk(ADR_MODEM_STAT, 8'h11);
    rd_chk(ADR_MODEM_STAT, 8'h10);
    modem_u.drive(5'h1A);
    idle(8);
    rd_chk(ADR_MODEM_STAT, 8'h50);
    modem_u.drive(5'h1E);
    idle(8);
    rd_chk(ADR_MODEM_STAT, 8'h14);
    modem_u.drive(5'h14);
    idle(8);
    rd_chk(ADR_MODEM_STAT, 8'hBA);
    modem_u.drive(5'h1F);
    idle(8);
    rd_chk(ADR_MODEM_STAT, 8'h0B);
  endtask
  task automatic t_regs();
    wr_reg(ADR_SCRATCH, 8'h5A);
    rd_chk(ADR_SCRATCH, 8'h5A);
    wr_reg(ADR_LINE_STAT, 8'hFF);
    rd_chk(ADR_LINE_STAT, 8'h60);
    wr_reg(ADR_DIV_FRAC, 8'h15);
    rd_chk(ADR_DIV_FRAC, 8'h00);
    wr_reg(ADR_MODEM_CTL, 8'hFF);
    rd_chk(ADR_MODEM_CTL, 8'h1F);
    #1;
    chk(8'h03, {6'h00, rts_n, dtr_n});
    rd_chk(ADR_MODEM_STAT, 8'hF0, 8'hF0);
    rd_chk(ADR_MODEM_STAT, 8'hF0);
    wr_reg(ADR_MODEM_CTL, 8'h00);
    wr_reg(ADR_ENH_FEAT, 8'h10);
    wr_reg(ADR_DIV_LOW, 8'h02);
    count_ticks(20, 8'h0A);
    wr_reg(ADR_DIV_FRAC, 8'h08);
    count_ticks(40, 8'h10);
    wr_reg(ADR_DIV_FRAC, 8'h00);
    wr_reg(ADR_MODEM_CTL, 8'h80);
    count_ticks(40, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      wr_reg(ADR_DIV_FRAC, 8'h0F | 8'(i << 4));
      #1;
      chk(8'(i), {6'h00, srate});
    end
    wr_reg(ADR_DIV_FRAC, 8'hFF);
    rd_chk(ADR_DIV_FRAC, 8'h3F);
    wr_reg(ADR_MODEM_CTL, 8'hE0);
    #1;
    chk(8'h01, {7'h00, xon_any});
    idle(2);
    chk(8'h00, {7'h00, tx_pin});
    wr_reg(ADR_ENH_FEAT, 8'h00);
    wr_reg(ADR_MODEM_CTL, 8'h00);
    rd_chk(ADR_MODEM_CTL, 8'hE0);
    for (int i = 0; i < 10; i++)
    begin
      wr_reg(ADR_ENH_FEAT, 8'h10);
      wr_reg(ADR_ENH_FEAT, {4'h1, FC_CODE[i]});
      #1;
      chk(FC_EXP[i], {3'h0, txfc, rxfc});
    end
    wr_reg(ADR_ENH_FEAT, 8'h90);
    idle(1);
    #1;
    chk(8'h01, {7'h00, tx_stop});
    modem_u.drive(5'h1E);
    idle(8);
    chk(8'h00, {7'h00, tx_stop});
  endtask
  // loopback turns each transmit bit into the receive bit; infrared pulses a zero bit
  task automatic t_loop(input logic [7:0] d);
    logic [7:0] got;
    got = 8'h00;
    wr_reg(ADR_MODEM_CTL, 8'h10);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      tx_bit <= d[i];
      idle(1);
      #1;
      got[i] = rx_core;
    end
    chk(d, got);
    chk(8'h01, {7'h00, tx_pin});
    wr_reg(ADR_MODEM_CTL, 8'h40);
    tx_bit <= 1'b0;
    idle(2);
    #1;
    chk(8'h01, {7'h00, tx_pin});
    tx_bit <= 1'b1;
    idle(2);
    chk(8'h00, {7'h00, tx_pin});
  endtask
  // main sequence: reset, scenarios, then a second reset must restore every register
  initial
  begin
    apply_reset();
    t_tx();
    t_rx();
    t_modem();
    t_regs();
    t_loop(8'hA6);
    modem_u.drive(5'h1F);
    apply_reset();
    complete_run();
  end
  // cut a hang short
  initial
  begin
    #400000;
    fail_count++;
    complete_run();
  end
endmodule
`default_nettype wire
